// file: shared/rab_defs.svh
// Offsets, field positions, masks and reset values of the register bank.
// Assumes inclusion by bare name from the design modules.
`ifndef RAB_DEFS_SVH
`define RAB_DEFS_SVH

`define RAB_ADDR_CTRL 3'h0
`define RAB_ADDR_STATUS 3'h1
`define RAB_ADDR_CMD 3'h2
`define RAB_ADDR_DBG 3'h3
`define RAB_ADDR_FLAGS_SET 3'h4
`define RAB_ADDR_FLAGS_CLR 3'h5

`define RAB_CTRL_MODE_LSB 0
`define RAB_CTRL_MODE_MSB 1
`define RAB_CTRL_EN_BIT 2
`define RAB_CTRL_RW_MASK 8'h3F
`define RAB_CTRL_RST 8'h00

`define RAB_STATUS_STATE_LSB 0
`define RAB_STATUS_STATE_MSB 1
`define RAB_STATUS_HW_LSB 2
`define RAB_STATUS_HW_MSB 5

`define RAB_CMD_GO_BIT 0
`define RAB_CMD_READ_VAL 8'h00

`define RAB_DBG_RW_MASK 8'h0F
`define RAB_DBG_RST 8'h00

`define RAB_FLAGS_RST 8'h00
`define RAB_UNMAPPED_READ 8'h00

`endif

// file: shared/rab_pkg.sv
// Types shared by the register bank and its set/clear store.
// Assumes the constants header is on the include path.
package rab_pkg;

  typedef logic [7:0] rab_data_t;
  typedef logic [2:0] rab_addr_t;

  // Gray along idle, run, done; 2'b10 is the reserved encoding
  typedef enum logic [1:0] {
    RAB_IDLE = 2'h0,
    RAB_RUN = 2'h1,
    RAB_DONE = 2'h3
  } rab_state_e;

  typedef struct packed {
    rab_data_t ctrl;
    rab_data_t dbg;
    rab_state_e state;
    logic go;
    rab_data_t rd_data;
    logic rd_valid;
  } rab_bank_s;

  typedef struct packed {
    rab_data_t value;
  } rab_flags_s;

endpackage

// file: shared/rab_sc_if.sv
// Link between the register bank and its shared set/clear bit vector.
// Assumes both ends run on the same clock.
interface rab_sc_if;
  rab_pkg::rab_data_t set_mask;
  rab_pkg::rab_data_t clr_mask;
  logic soft_rst;
  rab_pkg::rab_data_t value;

  modport bank (
    output set_mask,
    output clr_mask,
    output soft_rst,
    input value
  );

  modport store (
    input set_mask,
    input clr_mask,
    input soft_rst,
    output value
  );
endinterface

// file: logic/rab_setclr.sv
// One bit vector seen through a set view and a clear view.
// Assumes masks hold ones only where the matching view is written this cycle.
`include "rab_defs.svh"

module rab_setclr (
  input wire logic clk,
  input wire logic rst_n,
  rab_sc_if.store sc
);

  rab_pkg::rab_flags_s s_q;
  rab_pkg::rab_flags_s s_d;

  always_comb begin
    s_d = s_q;
    // Zeros in either mask keep the bit; clear beats set on overlap
    s_d.value = (s_q.value | sc.set_mask) & ~sc.clr_mask; // see R10, R11, R12, R14, R15
    if (sc.soft_rst) begin
      s_d.value = `RAB_FLAGS_RST; // see R9
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.value <= `RAB_FLAGS_RST; // see R9
    end else begin
      s_q <= s_d;
    end
  end

  // Single source for both views
  assign sc.value = s_q.value; // see R13

endmodule

// file: logic/rab_bank.sv
// Register bank: read/write, read-only, write-only and set/clear registers.
// Assumes synchronous access strobes from the CPU side, one clock domain.
//
// Function
// R1: Read/write bits store and return writes
// R2: Read-only bits ignore writes
// R3: Write-only bits accept writes, reads undefined
// R4: Reserved bits always read zero
// R5: Software writes zero to reserved bits
// R6: Software never writes reserved field encodings
// R7: Read-only fields never show reserved encodings
// R8: Programmer writes nothing to reserved fuse bits
// R9: Reset values after power and software reset; software reset leaves debug control unchanged
// R10: Set and clear views share one vector
// R11: One via clear view clears bit
// R12: One via set view sets bit
// R13: Both views read the same value
// R14: Simultaneous set and clear: clear wins
// R15: Zero via either view changes nothing
`include "rab_defs.svh"

module rab_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic periph_rst,
  input wire logic wr_a_en,
  input wire logic [2:0] wr_a_addr,
  input wire logic [7:0] wr_a_data,
  input wire logic wr_b_en,
  input wire logic [2:0] wr_b_addr,
  input wire logic [7:0] wr_b_data,
  input wire logic rd_en,
  input wire logic [2:0] rd_addr,
  input wire logic [3:0] hw_status,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [1:0] ctrl_mode,
  output logic ctrl_en,
  output logic [7:0] dbg_ctrl,
  output logic cmd_go,
  output logic [1:0] run_state,
  output logic [7:0] flags
);

  rab_pkg::rab_bank_s s_q;
  rab_pkg::rab_bank_s s_d;
  rab_pkg::rab_data_t status_view;
  rab_pkg::rab_data_t set_mask;
  rab_pkg::rab_data_t clr_mask;

  rab_sc_if sc ();

  // Write strobe decode, shared by both write ports
  function automatic logic hit(input logic en, input rab_pkg::rab_addr_t a,
                               input rab_pkg::rab_addr_t target);
    hit = en && (a == target);
  endfunction

  rab_setclr rab_setclr_i (
    .clk(clk),
    .rst_n(rst_n),
    .sc(sc)
  );

  always_comb begin
    set_mask = 8'h00;
    clr_mask = 8'h00;
    if (hit(wr_a_en, wr_a_addr, `RAB_ADDR_FLAGS_SET)) begin
      set_mask = set_mask | wr_a_data; // see R12
    end
    if (hit(wr_b_en, wr_b_addr, `RAB_ADDR_FLAGS_SET)) begin
      set_mask = set_mask | wr_b_data; // see R12
    end
    if (hit(wr_a_en, wr_a_addr, `RAB_ADDR_FLAGS_CLR)) begin
      clr_mask = clr_mask | wr_a_data; // see R11
    end
    if (hit(wr_b_en, wr_b_addr, `RAB_ADDR_FLAGS_CLR)) begin
      clr_mask = clr_mask | wr_b_data; // see R11
    end
  end

  assign sc.set_mask = set_mask;
  assign sc.clr_mask = clr_mask;
  assign sc.soft_rst = periph_rst;

  // Read-only view: reserved top bits zero, state never 2'b10
  always_comb begin
    status_view = 8'h00; // see R4
    status_view[`RAB_STATUS_HW_MSB:`RAB_STATUS_HW_LSB] = hw_status; // see R2
    status_view[`RAB_STATUS_STATE_MSB:`RAB_STATUS_STATE_LSB] = s_q.state; // see R7
  end

  always_comb begin
    s_d = s_q;
    s_d.go = 1'b0;

    if (hit(wr_a_en, wr_a_addr, `RAB_ADDR_CTRL)) begin
      s_d.ctrl = wr_a_data & `RAB_CTRL_RW_MASK; // see R1, R4
    end
    if (hit(wr_a_en, wr_a_addr, `RAB_ADDR_DBG)) begin
      s_d.dbg = wr_a_data & `RAB_DBG_RW_MASK; // see R1, R4
    end
    if (hit(wr_a_en, wr_a_addr, `RAB_ADDR_CMD)) begin
      s_d.go = wr_a_data[`RAB_CMD_GO_BIT]; // see R3
    end

    // Small sequencer whose state is the read-only status field
    case (s_q.state)
      rab_pkg::RAB_IDLE: begin
        if (s_q.ctrl[`RAB_CTRL_EN_BIT]) begin
          s_d.state = rab_pkg::RAB_RUN;
        end
      end
      rab_pkg::RAB_RUN: begin
        if (!s_q.ctrl[`RAB_CTRL_EN_BIT]) begin
          s_d.state = rab_pkg::RAB_IDLE;
        end else if (s_q.go) begin
          s_d.state = rab_pkg::RAB_DONE;
        end
      end
      rab_pkg::RAB_DONE: begin
        if (!s_q.ctrl[`RAB_CTRL_EN_BIT]) begin
          s_d.state = rab_pkg::RAB_IDLE;
        end
      end
      default: begin
        s_d.state = rab_pkg::RAB_IDLE; // see R7
      end
    endcase

    s_d.rd_valid = rd_en;
    if (rd_en) begin
      case (rd_addr)
        `RAB_ADDR_CTRL: s_d.rd_data = s_q.ctrl; // see R1, R4
        `RAB_ADDR_STATUS: s_d.rd_data = status_view; // see R2
        `RAB_ADDR_CMD: s_d.rd_data = `RAB_CMD_READ_VAL; // see R3
        `RAB_ADDR_DBG: s_d.rd_data = s_q.dbg; // see R1
        `RAB_ADDR_FLAGS_SET: s_d.rd_data = sc.value; // see R13
        `RAB_ADDR_FLAGS_CLR: s_d.rd_data = sc.value; // see R13
        default: s_d.rd_data = `RAB_UNMAPPED_READ;
      endcase
    end

    // Peripheral reset restores all but the debug control register
    if (periph_rst) begin
      s_d.ctrl = `RAB_CTRL_RST; // see R9
      // Debug control keeps its value; a write in the reset cycle is dropped
      s_d.dbg = s_q.dbg; // see R9
      s_d.state = rab_pkg::RAB_IDLE; // see R9
      s_d.go = 1'b0;
      s_d.rd_data = 8'h00;
      s_d.rd_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.ctrl <= `RAB_CTRL_RST; // see R9
      s_q.dbg <= `RAB_DBG_RST; // see R9
      s_q.state <= rab_pkg::RAB_IDLE;
      s_q.go <= 1'b0;
      s_q.rd_data <= 8'h00;
      s_q.rd_valid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd_data;
  assign rd_valid = s_q.rd_valid;
  assign ctrl_mode = s_q.ctrl[`RAB_CTRL_MODE_MSB:`RAB_CTRL_MODE_LSB];
  assign ctrl_en = s_q.ctrl[`RAB_CTRL_EN_BIT];
  assign dbg_ctrl = s_q.dbg;
  assign cmd_go = s_q.go;
  assign run_state = s_q.state;
  assign flags = sc.value;

endmodule

// file: tb/rab_bank_monitor.sv
// Concurrent checks on the register bank ports.
// Assumes binding to rab_bank in a single clock domain.
module rab_bank_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic periph_rst,
  input wire logic wr_a_en,
  input wire logic [2:0] wr_a_addr,
  input wire logic [7:0] wr_a_data,
  input wire logic wr_b_en,
  input wire logic [2:0] wr_b_addr,
  input wire logic [7:0] wr_b_data,
  input wire logic rd_en,
  input wire logic [2:0] rd_addr,
  input wire logic [3:0] hw_status,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic [1:0] ctrl_mode,
  input wire logic ctrl_en,
  input wire logic [7:0] dbg_ctrl,
  input wire logic cmd_go,
  input wire logic [1:0] run_state,
  input wire logic [7:0] flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] set_m;
  logic [7:0] clr_m;
  assign set_m = (wr_a_en && wr_a_addr == 3'h4 ? wr_a_data : 8'h00)
    | (wr_b_en && wr_b_addr == 3'h4 ? wr_b_data : 8'h00);
  assign clr_m = (wr_a_en && wr_a_addr == 3'h5 ? wr_a_data : 8'h00)
    | (wr_b_en && wr_b_addr == 3'h5 ? wr_b_data : 8'h00);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_rd_pulse;
    rd_en && !periph_rst |=> rd_valid;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read not answered");
  property p_ctrl_wr;
    wr_a_en && wr_a_addr == 3'h0 && !periph_rst |=> {ctrl_en, ctrl_mode} == 3'($past(wr_a_data));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");
  property p_ro_status;
    rd_en && rd_addr == 3'h1 && !periph_rst
      |=> rd_data == {2'h0, $past(hw_status), $past(run_state)};
  endproperty
  a_ro_status: assert property (p_ro_status) else $error("status read wrong");
  property p_wo_cmd;
    rd_en && rd_addr == 3'h2 && !periph_rst |=> rd_data == 8'h00;
  endproperty
  a_wo_cmd: assert property (p_wo_cmd) else $error("command read not zero");
  property p_res_bits;
    dbg_ctrl[7:4] == 4'h0 && run_state != 2'h2;
  endproperty
  a_res_bits: assert property (p_res_bits) else $error("reserved value seen");
  property p_views;
    rd_en && rd_addr[2:1] == 2'h2 && !periph_rst |=> rd_data == $past(flags);
  endproperty
  a_views: assert property (p_views) else $error("view read differs");
  property p_flags_next;
    !periph_rst |=> flags == (($past(flags) | $past(set_m)) & ~$past(clr_m));
  endproperty
  a_flags_next: assert property (p_flags_next) else $error("flag update wrong");
  property p_soft_rst;
    periph_rst |=> flags == 8'h00 && run_state == 2'h0 && !ctrl_en && ctrl_mode == 2'h0
      && !rd_valid && $stable(dbg_ctrl);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset wrong");
  c_collide: cover property ((set_m & clr_m) != 8'h00 && !periph_rst);
  c_go: cover property (cmd_go);
  c_done: cover property (run_state == 2'h3);
endmodule

// file: tb/rab_bank_test.sv
// Self-checking bench for the register bank with a reference model.
// Assumes the design files and the monitor are compiled first.
module rab_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0, periph_rst = 1'h0, wr_a_en = 1'h0, wr_b_en = 1'h0;
  logic rd_en = 1'h0;
  logic [2:0] wr_a_addr = 3'h0, wr_b_addr = 3'h0, rd_addr = 3'h0;
  logic [7:0] wr_a_data = 8'h00, wr_b_data = 8'h00, rd_data, dbg_ctrl, flags;
  logic [3:0] hw_status = 4'h0;
  logic rd_valid, ctrl_en, cmd_go, rv, go;
  logic [1:0] ctrl_mode, run_state, st;
  logic [7:0] ctrl, dbg, rd, fl;
  logic [31:0] r;
  int err_total = 0, total_checks = 0;
  wire [30:0] seen = {rd_valid, rd_data, ctrl_en, ctrl_mode, dbg_ctrl, cmd_go, run_state, flags};
  wire [30:0] want = {rv, rd, ctrl[2:0], dbg, go, st, fl};
  always #20 clk = ~clk;
  rab_bank rab_bank_i (.*);
  function automatic logic [7:0] hit(logic e, logic [2:0] a, logic [7:0] d, logic [2:0] t);
    return e && a == t ? d : 8'h00;
  endfunction
  // Software side: zero reserved bits, no reserved mode encoding
  function automatic logic [7:0] legal(logic [2:0] a, logic [7:0] d);
    if (a == 3'h0) return {2'h0, d[5:2], (d[1:0] == 2'h3) ? 2'h0 : d[1:0]};
    if (a == 3'h3) return {4'h0, d[3:0]};
    return d;
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(logic ea, logic [2:0] aa, logic [7:0] da, logic eb, logic [2:0] ab,
                     logic [7:0] db, logic re, logic [2:0] ra, logic pr);
    @(posedge clk);
    {wr_a_en, wr_a_addr, wr_a_data, wr_b_en, wr_b_addr, wr_b_data} <= {ea, aa, da, eb, ab, db};
    {rd_en, rd_addr, periph_rst, hw_status} <= {re, ra, pr, 4'($urandom)};
    @(negedge clk);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] outputs expected %h seen %h", want, seen);
    end
    if (pr) begin
      {ctrl, st, go, rd, rv, fl} = '0;
    end else begin
      rv = re;
      if (re) rd = ra == 3'h0 ? ctrl : ra == 3'h1 ? {2'h0, hw_status, st} :
        ra == 3'h3 ? dbg : ra[2:1] == 2'h2 ? fl : 8'h00;
      st = !ctrl[2] ? 2'h0 : st == 2'h0 ? 2'h1 : (st == 2'h1 && go) ? 2'h3 : st;
      go = ea && aa == 3'h2 && da[0];
      if (ea && aa == 3'h0) ctrl = da & 8'h3F;
      if (ea && aa == 3'h3) dbg = da & 8'h0F;
      fl = (fl | hit(ea, aa, da, 3'h4) | hit(eb, ab, db, 3'h4))
        & ~(hit(ea, aa, da, 3'h5) | hit(eb, ab, db, 3'h5));
    end
  endtask
  initial begin
    #80000;
    err_total++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hA53ABE91));
    {ctrl, dbg, rd, fl, st, rv, go} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    cyc(1, 3'h0, 8'hFF, 1, 3'h0, 8'h3C, 0, 3'h0, 0);
    cyc(1, 3'h1, 8'hFF, 1, 3'h4, 8'hF0, 1, 3'h0, 0);
    cyc(1, 3'h5, 8'h30, 1, 3'h4, 8'h3C, 1, 3'h1, 0);
    cyc(1, 3'h2, 8'h01, 0, 3'h0, 8'h00, 1, 3'h4, 0);
    cyc(1, 3'h3, 8'hFF, 0, 3'h0, 8'h00, 1, 3'h5, 0);
    cyc(1, 3'h4, 8'h00, 1, 3'h5, 8'h00, 1, 3'h2, 0);
    cyc(1, 3'h0, 8'h00, 0, 3'h0, 8'h00, 1, 3'h6, 1);
    cyc(0, 3'h0, 8'h00, 0, 3'h0, 8'h00, 1, 3'h3, 0);
    repeat (400) begin
      r = $urandom;
      cyc(r[0], r[3:1], legal(r[3:1], r[11:4]), r[12], r[15:13], r[23:16], r[24], r[27:25],
          r[31:28] == 4'h0);
    end
    wrap_up();
  end
endmodule
bind rab_bank rab_bank_monitor rab_bank_monitor_i (.*);
